// ### rfc_pkg.sv
package rfc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_INT   = 8'h04;
  localparam logic [7:0] A_MASK  = 8'h08;
  localparam logic [7:0] A_FSTAT = 8'h0c;
  localparam logic [7:0] A_FDATA = 8'h10;
  localparam logic [7:0] A_FDT   = 8'h14;
  localparam logic [7:0] A_ADC   = 8'h18;
  localparam logic [7:0] A_RX    = 8'h1c;
  localparam logic [7:0] A_CMD   = 8'h20;

  // Control register fields
  localparam int B_TXEN = 0;
  localparam int B_ISOA = 1;
  localparam int B_NFC  = 2;
  localparam int B_WLRX = 3;
  localparam int B_WLTX = 4;
  localparam int B_GAIN = 8;
  localparam int GAIN_W = 4;
  localparam logic [12:0] CTRL_RST = 13'h0000;
  localparam logic [3:0]  MASK_RST = 4'h0;
  localparam logic [7:0]  FDT_RST  = 8'h00;

  // Interrupt bits
  localparam int I_WL  = 0;
  localparam int I_EOT = 1;
  localparam int I_NFC = 2;
  localparam int I_ADC = 3;
  localparam int INT_W = 4;

  // FIFO status fields
  localparam int B_OVF = 6;

  // ----------------------------------------------------------------
  // Direct commands
  // ----------------------------------------------------------------
  localparam logic [1:0] DCMD_MODE = 2'h3;
  localparam logic [5:0] C_DEFAULT = 6'h01;
  localparam logic [5:0] C_CLEAR   = 6'h02;
  localparam logic [5:0] C_TXCRC   = 6'h04;
  localparam logic [5:0] C_TXRAW   = 6'h05;
  localparam logic [5:0] C_REQA    = 6'h06;
  localparam logic [5:0] C_WUPA    = 6'h07;
  localparam logic [5:0] C_NFCI    = 6'h08;
  localparam logic [5:0] C_NFCR    = 6'h09;
  localparam logic [5:0] C_NFC0    = 6'h0a;
  localparam logic [5:0] C_MASK    = 6'h10;
  localparam logic [5:0] C_UNMASK  = 6'h11;
  localparam logic [5:0] C_ADC     = 6'h12;
  localparam logic [5:0] C_RF      = 6'h13;
  localparam logic [5:0] C_SQ      = 6'h14;
  localparam logic [5:0] C_SQCLR   = 6'h15;

  localparam logic [7:0] REQA_BYTE = 8'h26;
  localparam logic [7:0] WUPA_BYTE = 8'h52;

  // ----------------------------------------------------------------
  // FIFO
  // ----------------------------------------------------------------
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FULL   = 6'h20;
  localparam logic [CNT_W-1:0] WL_TX0 = 6'h08;
  localparam logic [CNT_W-1:0] WL_TX1 = 6'h10;
  localparam logic [CNT_W-1:0] WL_RX0 = 6'h10;
  localparam logic [CNT_W-1:0] WL_RX1 = 6'h18;

  // ----------------------------------------------------------------
  // Timing (ns) and derived cycle counts, rounded up
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 8;
  localparam int IRFG_NS  = 5110000;
  localparam int RWF_NS   = 37760;
  localparam int GAS_NS   = 65000;
  localparam int IRFG_CYC = (IRFG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RWF_CYC  = (RWF_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAS_CYC  = (GAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W    = 20;

endpackage : rfc_pkg

// ### rfc_ctrl.sv
// Summary of operation
// [RULE_01] Transmitting: interrupt when unsent FIFO data falls below tx level.
// [RULE_02] Receiving: interrupt when stored bytes rise above rx level.
// [RULE_03] Two selectable water levels each for receive and transmit.
// [RULE_04] Status shows bytes in the FIFO not yet read.
// [RULE_05] Overflow flag when receive exceeds 32 bytes; extra data dropped.
// [RULE_06] Host should service FIFO faster than the air bit rate.
// [RULE_07] Code 000001 restores all defaults in every mode.
// [RULE_08] Code 000010 aborts activity, empties FIFO, zeroes collision, interrupts.
// [RULE_09] Host issues clear before a transmit, except REQA and WUPA.
// [RULE_10] 000100 sends with CRC, 000101 without; need transmitter enable.
// [RULE_11] 000110 sends REQA, 000111 WUPA; only in ISO-14443A mode.
// [RULE_12] 001000..001010 peer transmit after collision avoidance against threshold.
// [RULE_13] Response variant picks n from 0..3; n-zero variant uses 0.
// [RULE_14] Collision during avoidance skips transmit, raises peer event interrupt.
// [RULE_15] Peer commands switch the field; host leaves transmitter enable clear.
// [RULE_16] Initial avoidance uses 5.11 ms guard and 37.76 us waiting time.
// [RULE_17] Field stays on 65 us after a peer request or response.
// [RULE_18] Peer end-of-transmit interrupt when the field switches off.
// [RULE_19] Peer commands need peer mode bit, oscillator and regulators running.
// [RULE_20] Code 010000 drives receiver active low, stops receive framing.
// [RULE_21] Code 010001 drives receiver active high, overrides mask timer.
// [RULE_22] 010010 converts analog input, 010011 measures RF into converter register.
// [RULE_23] Direct command is one byte 11 plus code, run on last clock.
// [RULE_24] Shared FIFO holds 32 bytes.
// [RULE_25] Reading interrupt register clears it and drops the alert line.
// [RULE_26] Undefined command codes are ignored without any effect.
// [RULE_27] 010100 reduces gain by noise; 010101 restores previous gain.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module rfc_ctrl #(
  parameter logic [19:0] GUARD_CYC = 20'(rfc_pkg::IRFG_CYC),
  parameter logic [19:0] RWF_CYC   = 20'(rfc_pkg::RWF_CYC),
  parameter logic [19:0] GAS_CYC   = 20'(rfc_pkg::GAS_CYC)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial command pins
  input  wire logic        sen,
  input  wire logic        sclk,
  input  wire logic        sdi,
  // Power state
  input  wire logic        oscReady,
  input  wire logic        regReady,
  // Transmit framing
  output logic [7:0]       txByte,
  output logic             txValid,
  input  wire logic        txReady,
  output logic             txCrc,
  output logic             txShort,
  output logic             rfField,
  // Receive framing
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  input  wire logic        maskTimerBusy,
  output logic             rxOn,
  // Analog
  input  wire logic [7:0]  fieldLevel,
  input  wire logic [7:0]  adIn,
  input  wire logic [7:0]  rfAmp,
  input  wire logic [3:0]  noiseLevel,
  output logic [3:0]       gain,
  // Alert
  output logic             hostAlertLine
);

  typedef enum logic [2:0] {
    S_IDLE, S_CA, S_SEND, S_SHORT, S_HOLD
  } rfc_state_e;

  // ----------------------------------------------------------------
  // Serial direct command capture
  // ----------------------------------------------------------------
  logic [2:0] pinS1, pinS2, pinS3, pinStable;
  logic [7:0] shiftReg;
  logic [2:0] bitCnt;
  logic       firstDone;
  logic       sclkFall, senHigh;
  logic       serCmd;
  logic [5:0] serCode;

  // Order: {sen, sclk, sdi}
  always_ff @(posedge clk)
  begin
    pinS1 <= {sen, sclk, sdi};
    pinS2 <= pinS1;
    pinS3 <= pinS2;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pinStable <= 3'h0;
    else
      pinStable <= (pinS2 & pinS3) | (pinStable & (pinS2 | pinS3));
  end

  assign senHigh  = pinStable[2];
  assign sclkFall = pinStable[1] && !pinS2[1] && !pinS3[1];

  // Only the first byte of a frame can carry a command
  always_ff @(posedge clk)
  begin
    serCmd <= 1'b0;
    if (!rst_n || !senHigh)
    begin
      bitCnt    <= 3'h0;
      firstDone <= 1'b0;
      shiftReg  <= 8'h00;
      serCode   <= 6'h00;
    end
    else if (sclkFall && !firstDone)
    begin
      shiftReg <= {shiftReg[6:0], pinStable[0]};
      bitCnt   <= bitCnt + 3'h1;
      if (bitCnt == 3'h7)
      begin
        firstDone <= 1'b1;
        serCmd    <= shiftReg[6:5] == rfc_pkg::DCMD_MODE; // see [RULE_23]
        serCode   <= {shiftReg[4:0], pinStable[0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       busCmd, cmdGo, swRst;
  logic [5:0] cmdCode;
  logic       isClr, isTxStd, isTxShort, isNfc;
  logic       apbWr, apbRd;

  assign apbWr   = psel && penable && pwrite;
  assign apbRd   = psel && penable && !pwrite;
  assign busCmd  = apbWr && paddr == rfc_pkg::A_CMD;
  assign cmdGo   = serCmd || busCmd;
  assign cmdCode = serCmd ? serCode : pwdata[5:0];
  // Codes outside the set match nothing below
  assign swRst   = !rst_n || (cmdGo && cmdCode == rfc_pkg::C_DEFAULT); // see [RULE_07] see [RULE_26]
  assign isClr   = cmdGo && cmdCode == rfc_pkg::C_CLEAR;
  assign isTxStd = cmdGo && (cmdCode == rfc_pkg::C_TXCRC ||
                             cmdCode == rfc_pkg::C_TXRAW);
  assign isTxShort = cmdGo && (cmdCode == rfc_pkg::C_REQA ||
                               cmdCode == rfc_pkg::C_WUPA);
  assign isNfc   = cmdGo && (cmdCode == rfc_pkg::C_NFCI ||
                             cmdCode == rfc_pkg::C_NFCR ||
                             cmdCode == rfc_pkg::C_NFC0);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [12:0] ctrl;
  logic [3:0]  intMask;
  logic [7:0]  fdt;
  logic [7:0]  adcOut;
  logic [3:0]  savedGain;
  logic        txEn, nfcOk;

  assign txEn  = ctrl[rfc_pkg::B_TXEN];
  assign nfcOk = ctrl[rfc_pkg::B_NFC] && oscReady && regReady; // see [RULE_19]
  assign gain  = ctrl[rfc_pkg::B_GAIN +: rfc_pkg::GAIN_W];

  always_ff @(posedge clk)
  begin
    if (swRst) // see [RULE_07]
    begin
      ctrl      <= rfc_pkg::CTRL_RST;
      intMask   <= rfc_pkg::MASK_RST;
      fdt       <= rfc_pkg::FDT_RST;
      savedGain <= 4'h0;
    end
    else if (cmdGo && cmdCode == rfc_pkg::C_SQ) // see [RULE_27]
    begin
      savedGain <= gain;
      ctrl[rfc_pkg::B_GAIN +: rfc_pkg::GAIN_W] <=
        gain > noiseLevel ? gain - noiseLevel : 4'h0;
    end
    else if (cmdGo && cmdCode == rfc_pkg::C_SQCLR) // see [RULE_27]
      ctrl[rfc_pkg::B_GAIN +: rfc_pkg::GAIN_W] <= savedGain;
    else if (apbWr)
    begin
      if (paddr == rfc_pkg::A_CTRL)
        ctrl <= pwdata[12:0];
      if (paddr == rfc_pkg::A_MASK)
        intMask <= pwdata[3:0];
      if (paddr == rfc_pkg::A_FDT)
        fdt <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (swRst)
      adcOut <= 8'h00;
    else if (cmdGo && cmdCode == rfc_pkg::C_ADC)
      adcOut <= adIn; // see [RULE_22]
    else if (cmdGo && cmdCode == rfc_pkg::C_RF)
      adcOut <= rfAmp; // see [RULE_22]
  end

  // ----------------------------------------------------------------
  // Receive masking
  // ----------------------------------------------------------------
  logic rxForce, rxAccept;

  always_ff @(posedge clk)
  begin
    if (swRst || (cmdGo && cmdCode == rfc_pkg::C_MASK))
    begin
      rxOn    <= 1'b0; // see [RULE_20]
      rxForce <= 1'b0;
    end
    else if (cmdGo && cmdCode == rfc_pkg::C_UNMASK)
    begin
      rxOn    <= 1'b1; // see [RULE_21]
      rxForce <= 1'b1;
    end
  end

  // Unmask outranks the internal mask timer
  assign rxAccept = rxValid && rxOn && (rxForce || !maskTimerBusy); // see [RULE_21]

  // ----------------------------------------------------------------
  // FIFO
  // ----------------------------------------------------------------
  logic [7:0]              mem [rfc_pkg::DEPTH];
  logic [rfc_pkg::PTR_W-1:0] wrPtr, rdPtr;
  logic [rfc_pkg::CNT_W-1:0] fifoCnt;
  logic        overflow, full, empty;
  logic        apbPush, rxPush, push, apbPop, txPop, pop;
  logic [7:0]  pushData;
  rfc_state_e  state;

  assign full    = fifoCnt == rfc_pkg::FULL; // see [RULE_24]
  assign empty   = fifoCnt == '0;
  assign apbPush = apbWr && paddr == rfc_pkg::A_FDATA && !full;
  // Bus load wins a same-cycle clash; the received byte is dropped
  assign rxPush  = rxAccept && !full && !apbPush && state == S_IDLE;
  assign push    = apbPush || rxPush;
  assign pushData = apbPush ? pwdata[7:0] : rxByte;
  assign apbPop  = apbRd && paddr == rfc_pkg::A_FDATA && !empty &&
                   state != S_SEND;
  assign txPop   = state == S_SEND && txReady && !empty;
  assign pop     = apbPop || txPop;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr] <= pushData;
  end

  always_ff @(posedge clk)
  begin
    if (swRst || isClr) // see [RULE_08]
    begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      fifoCnt <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 5'h01;
      if (pop)
        rdPtr <= rdPtr + 5'h01;
      fifoCnt <= fifoCnt + 6'(push) - 6'(pop); // see [RULE_04]
    end
  end

  always_ff @(posedge clk)
  begin
    if (swRst || isClr)
      overflow <= 1'b0;
    else if (rxAccept && full && state == S_IDLE)
      overflow <= 1'b1; // see [RULE_05]
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  logic [19:0] timer;
  logic [1:0]  slots;
  logic        nfcRun, collided;
  logic [7:0]  lfsr, shortByte;
  logic        eotEv, collEv;

  // Free-running source of the random slot count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lfsr <= 8'h01;
    else
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end

  assign collEv = state == S_CA && fieldLevel > fdt; // see [RULE_12]
  assign eotEv  = (state == S_SEND && empty && !nfcRun) ||
                  (state == S_SHORT && txReady) ||
                  (state == S_HOLD && timer == '0);

  always_ff @(posedge clk)
  begin
    if (swRst || isClr) // see [RULE_08]
    begin
      state    <= S_IDLE;
      nfcRun   <= 1'b0;
      rfField  <= 1'b0;
      timer    <= '0;
      slots    <= 2'h0;
      txCrc    <= 1'b0;
      collided <= 1'b0;
      shortByte <= 8'h00;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (isTxStd && txEn) // see [RULE_10]
          begin
            txCrc <= cmdCode == rfc_pkg::C_TXCRC;
            state <= S_SEND;
          end
          else if (isTxShort && txEn && ctrl[rfc_pkg::B_ISOA]) // see [RULE_11]
          begin
            shortByte <= cmdCode == rfc_pkg::C_REQA ?
                         rfc_pkg::REQA_BYTE : rfc_pkg::WUPA_BYTE;
            state <= S_SHORT;
          end
          else if (isNfc && nfcOk) // see [RULE_12] see [RULE_15]
          begin
            txCrc  <= 1'b1;
            nfcRun <= 1'b1;
            state  <= S_CA;
            if (cmdCode == rfc_pkg::C_NFCI)
            begin
              timer <= GUARD_CYC - 20'h1; // see [RULE_16]
              slots <= 2'h1;
            end
            else
            begin
              timer <= RWF_CYC - 20'h1;
              slots <= cmdCode == rfc_pkg::C_NFCR ? lfsr[1:0] : 2'h0; // see [RULE_13]
            end
          end
        end
        S_CA:
        begin
          if (collEv) // see [RULE_14]
          begin
            collided <= 1'b1;
            nfcRun   <= 1'b0;
            state    <= S_IDLE;
          end
          else if (timer != '0)
            timer <= timer - 20'h1;
          else if (slots != 2'h0)
          begin
            slots <= slots - 2'h1;
            timer <= RWF_CYC - 20'h1; // see [RULE_16]
          end
          else
          begin
            rfField <= 1'b1; // see [RULE_15]
            state   <= S_SEND;
          end
        end
        S_SEND:
        begin
          if (empty && nfcRun)
          begin
            timer <= GAS_CYC - 20'h1; // see [RULE_17]
            state <= S_HOLD;
          end
          else if (empty)
            state <= S_IDLE;
        end
        S_SHORT:
          if (txReady)
            state <= S_IDLE;
        S_HOLD:
        begin
          if (timer != '0)
            timer <= timer - 20'h1;
          else
          begin
            rfField <= 1'b0; // see [RULE_18]
            nfcRun  <= 1'b0;
            state   <= S_IDLE;
          end
        end
      endcase
    end
  end

  assign txValid = (state == S_SEND && !empty) || state == S_SHORT;
  assign txShort = state == S_SHORT;
  assign txByte  = state == S_SHORT ? shortByte : mem[rdPtr];

  // ----------------------------------------------------------------
  // Water levels and interrupts
  // ----------------------------------------------------------------
  logic [rfc_pkg::CNT_W-1:0] txLevel, rxLevel;
  logic       wlCond, wlPrev, intRead;
  logic [3:0] host_alert_line, setV, next_host_alert_line;

  assign txLevel = ctrl[rfc_pkg::B_WLTX] ? rfc_pkg::WL_TX1
                                         : rfc_pkg::WL_TX0; // see [RULE_03]
  assign rxLevel = ctrl[rfc_pkg::B_WLRX] ? rfc_pkg::WL_RX1
                                         : rfc_pkg::WL_RX0; // see [RULE_03]
  assign wlCond  = (state == S_SEND && fifoCnt < txLevel) || // see [RULE_01]
                   (state == S_IDLE && rxOn && fifoCnt > rxLevel); // see [RULE_02]
  assign intRead = apbRd && paddr == rfc_pkg::A_INT;

  always_ff @(posedge clk)
  begin
    if (swRst || isClr)
      wlPrev <= 1'b0;
    else
      wlPrev <= wlCond;
  end

  always_comb
  begin
    setV = 4'h0;
    setV[rfc_pkg::I_WL]  = wlCond && !wlPrev;
    setV[rfc_pkg::I_EOT] = eotEv;
    setV[rfc_pkg::I_NFC] = collEv;
    setV[rfc_pkg::I_ADC] = cmdGo && (cmdCode == rfc_pkg::C_ADC ||
                                     cmdCode == rfc_pkg::C_RF);
    // A new event outlives the read that clears the others
    next_host_alert_line = setV | (intRead ? 4'h0 : host_alert_line); // see [RULE_25]
  end

  always_ff @(posedge clk)
  begin
    if (swRst || isClr) // see [RULE_08]
    begin
      host_alert_line          <= 4'h0;
      hostAlertLine <= 1'b0;
    end
    else
    begin
      host_alert_line          <= next_host_alert_line;
      hostAlertLine <= |(next_host_alert_line & ~intMask); // see [RULE_25]
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  assign pready = 1'b1;

  always_comb
  begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    unique case (paddr)
      rfc_pkg::A_CTRL:  prdata[12:0] = ctrl;
      rfc_pkg::A_INT:   prdata[3:0]  = host_alert_line;
      rfc_pkg::A_MASK:  prdata[3:0]  = intMask;
      rfc_pkg::A_FSTAT: prdata[6:0]  = {overflow, fifoCnt}; // see [RULE_04]
      rfc_pkg::A_FDATA: prdata[7:0]  = mem[rdPtr];
      rfc_pkg::A_FDT:   prdata[7:0]  = fdt;
      rfc_pkg::A_ADC:   prdata[7:0]  = adcOut;
      rfc_pkg::A_RX:    prdata[2:0]  = {collided, rxForce, rxOn};
      rfc_pkg::A_CMD:   prdata       = 32'h0;
      default:          pslverr      = psel && penable;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence holdEntry;
    state == S_SEND && empty && nfcRun && !isClr && !swRst;
  endsequence

  sequence fieldHeld;
    rfField [*8];
  endsequence

  a_txen_gate: assert property (state == S_IDLE && isTxStd && !txEn && !isClr
    |=> state == S_IDLE) else $error("tx started while disabled"); // see [RULE_10]
  a_clear_all: assert property (isClr && !swRst
    |=> fifoCnt == '0 && host_alert_line == 4'h0 && !collided)
    else $error("clear left state behind"); // see [RULE_08]
  a_default_ctrl: assert property (swRst |=> ctrl == rfc_pkg::CTRL_RST
    && state == S_IDLE) else $error("default not restored"); // see [RULE_07]
  a_ovf_flag: assert property (rxAccept && full && state == S_IDLE && !isClr
    && !swRst |=> overflow && fifoCnt == rfc_pkg::FULL)
    else $error("overflow not flagged"); // see [RULE_05]
  a_read_clears: assert property (intRead && setV == 4'h0 && !isClr
    |=> host_alert_line == 4'h0 && !hostAlertLine)
    else $error("read did not clear"); // see [RULE_25]
  a_mask_rx: assert property (cmdGo && cmdCode == rfc_pkg::C_MASK
    |=> !rxOn && !rxPush) else $error("receive not masked"); // see [RULE_20]
  a_nfc_reject: assert property (state == S_IDLE && isNfc && !nfcOk
    |=> state == S_IDLE && !rfField)
    else $error("peer tx not rejected"); // see [RULE_19]
  a_coll_skip: assert property (collEv && !isClr && !swRst
    |=> state == S_IDLE && host_alert_line[rfc_pkg::I_NFC] && !rfField)
    else $error("collision not handled"); // see [RULE_14]
  a_gas_hold: assert property (holdEntry |=> fieldHeld)
    else $error("field dropped early"); // see [RULE_17]
  a_eot_off: assert property ($fell(rfField) && !$past(isClr) && !$past(swRst)
    |-> host_alert_line[rfc_pkg::I_EOT]) else $error("no eot at field off"); // see [RULE_18]
  a_fifo_cap: assert property (fifoCnt <= rfc_pkg::FULL)
    else $error("fifo count above depth"); // see [RULE_24]

endmodule : rfc_ctrl

// ### rfc_host_model.sv
`timescale 1ns/1ps
module rfc_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      sen,
  output logic      sclk,
  output logic      sdi
);
  initial
  begin
    sen = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // Released data line must not keep its last level
  always @(posedge clk)
    if (!sen)
      sdi <= ~sdi;

  // One command byte, MSB first; 80 ns link clock
  task automatic send(input logic [5:0] code);
    logic [7:0] b;
    b = {2'b11, code};
    sen <= 1'b1;
    @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      sdi <= b[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    sen <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : send
endmodule : rfc_host_model

// ### rf_reader_command_fifo_ctrl_test.sv
`timescale 1ns/1ps
module rf_reader_command_fifo_ctrl_test;
  logic        clk, err, pready, pslverr, txValid, rxOn, sen, sclk, sdi;
  logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        txReady = 1'b0, rxValid = 1'b0;
  logic [7:0]  paddr = 8'h00, rxByte = 8'h00, adIn = 8'h00, rfAmp = 8'h00;
  logic [7:0]  b0, txByte;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  expQ[$];
  logic [5:0]  codes[4] = '{rfc_pkg::C_TXCRC, rfc_pkg::C_TXRAW,
                            rfc_pkg::C_REQA, rfc_pkg::C_WUPA};
  logic        oscReady = 1'b1, regReady = 1'b1, maskTimerBusy = 1'b0;
  logic [7:0]  fieldLevel = 8'h00;
  logic [3:0]  noiseLevel = 4'h0;
  int          nFail, nTests;

  rfc_ctrl #(.GUARD_CYC(20'd20), .RWF_CYC(20'd5), .GAS_CYC(20'd10))
  rfc_ctrl_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sen, .sclk, .sdi, .oscReady,
    .regReady, .txByte, .txValid, .txReady, .txCrc(), .txShort(),
    .rfField(), .rxByte, .rxValid, .maskTimerBusy, .rxOn,
    .fieldLevel, .adIn, .rfAmp, .noiseLevel, .gain(),
    .hostAlertLine());
  rfc_host_model rfc_host_model_i (.clk, .sen, .sclk, .sdi);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nFail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      nFail++;
      conclude();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Far side stalls at random
  always @(posedge clk)
    txReady <= 1'($urandom);

  // --------------------------------------------------------------
  // Transmit scoreboard
  // --------------------------------------------------------------
  always @(posedge clk)
    if (txValid === 1'b1 && txReady === 1'b1)
      check({24'h0, txByte},
        expQ.size() > 0 ? {24'h0, expQ.pop_front()} : 32'hffffffff);

  initial
  begin
    void'($urandom(32'h8a87f315));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, rfc_pkg::A_CTRL, 0, rd);
    check(rd, 32'h0);
    apb(0, 8'h24, 0, rd);
    check({31'h0, err}, 32'h1);
    apb(1, rfc_pkg::A_FDATA, 32'h5a, rd);
    rfc_host_model_i.send(rfc_pkg::C_TXCRC);
    apb(0, rfc_pkg::A_FSTAT, 0, rd);
    check(rd, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, rfc_pkg::A_CMD, {26'h0, rfc_pkg::C_CLEAR}, rd);
      apb(1, rfc_pkg::A_CTRL, 32'h3, rd);
      for (int j = 0; j < 3 && k < 2; j++)
      begin
        b0 = 8'($urandom);
        expQ.push_back(b0);
        apb(1, rfc_pkg::A_FDATA, {24'h0, b0}, rd);
      end
      if (k > 1)
        expQ.push_back(k == 2 ? rfc_pkg::REQA_BYTE : rfc_pkg::WUPA_BYTE);
      rfc_host_model_i.send(codes[k]);
      for (int n = 0; expQ.size() > 0; n++)
      begin
        if (n == 300)
        begin
          nFail++;
          conclude();
        end
        @(posedge clk);
      end
      repeat (3) @(posedge clk);
      apb(0, rfc_pkg::A_INT, 0, rd);
      if (k < 2)
        check(rd & 32'h2, 32'h2);
    end
    apb(0, rfc_pkg::A_INT, 0, rd);
    check(rd, 32'h0);
    rfc_host_model_i.send(rfc_pkg::C_UNMASK);
    check({31'h0, rxOn}, 32'h1);
    // Unmask must outrank a busy mask timer
    maskTimerBusy <= 1'b1;
    for (int j = 0; j < 33; j++)
    begin
      rxByte <= 8'($urandom);
      rxValid <= 1'b1;
      @(posedge clk);
      if (j == 0)
        b0 = rxByte;
      rxValid <= 1'b0;
      @(posedge clk);
    end
    apb(0, rfc_pkg::A_FSTAT, 0, rd);
    check(rd, 32'h60);
    apb(0, rfc_pkg::A_INT, 0, rd);
    check(rd & 32'h1, 32'h1);
    apb(0, rfc_pkg::A_FDATA, 0, rd);
    check(rd, {24'h0, b0});
    apb(0, rfc_pkg::A_FSTAT, 0, rd);
    check({26'h0, rd[5:0]}, 32'h1f);
    rfc_host_model_i.send(rfc_pkg::C_MASK);
    check({31'h0, rxOn}, 32'h0);
    rfc_host_model_i.send(rfc_pkg::C_CLEAR);
    apb(0, rfc_pkg::A_FSTAT, 0, rd);
    check(rd, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      adIn <= 8'($urandom);
      rfAmp <= 8'($urandom);
      @(posedge clk);
      apb(1, rfc_pkg::A_CMD,
          {26'h0, k ? rfc_pkg::C_RF : rfc_pkg::C_ADC}, rd);
      apb(0, rfc_pkg::A_ADC, 0, rd);
      check(rd, {24'h0, k ? rfAmp : adIn});
    end
    // Peer mode: refused without regulators, then a response frame
    apb(1, rfc_pkg::A_CTRL, 32'h4, rd);
    regReady <= 1'b0;
    apb(1, rfc_pkg::A_FDATA, 32'h3c, rd);
    apb(1, rfc_pkg::A_CMD, {26'h0, rfc_pkg::C_NFC0}, rd);
    apb(0, rfc_pkg::A_FSTAT, 0, rd);
    check(rd, 32'h1);
    regReady <= 1'b1;
    expQ.push_back(8'h3c);
    apb(1, rfc_pkg::A_CMD, {26'h0, rfc_pkg::C_NFCR}, rd);
    repeat (80) @(posedge clk);
    check(expQ.size(), 0);
    apb(0, rfc_pkg::A_INT, 0, rd);
    check(rd & 32'h6, 32'h2);
    fieldLevel <= 8'h10;
    apb(1, rfc_pkg::A_CMD, {26'h0, rfc_pkg::C_NFCI}, rd);
    repeat (5) @(posedge clk);
    apb(0, rfc_pkg::A_INT, 0, rd);
    check(rd & 32'h4, 32'h4);
    apb(1, rfc_pkg::A_CTRL, 32'h0f04, rd);
    rfc_host_model_i.send(6'h3f);
    apb(0, rfc_pkg::A_CTRL, 0, rd);
    check(rd, 32'h0f04);
    noiseLevel <= 4'h3;
    apb(1, rfc_pkg::A_CMD, {26'h0, rfc_pkg::C_SQ}, rd);
    apb(0, rfc_pkg::A_CTRL, 0, rd);
    check(rd, 32'h0c04);
    rfc_host_model_i.send(rfc_pkg::C_DEFAULT);
    apb(0, rfc_pkg::A_CTRL, 0, rd);
    check(rd, 32'h0);
    conclude();
  end
endmodule : rf_reader_command_fifo_ctrl_test
